// ---- msr_modem_model.sv ----
// behavioural local modem that drives the interface status lines
`timescale 1ns/10ps
`default_nettype none
// ==========
// modem model
module msr_modem_model import msr_pkg::*; (
    input wire logic i_clock,
    input wire msr_lines_s i_want,
    input wire logic i_want_int,
    output msr_lines_s o_lines,
    output logic o_int_carrier
);
    // lines move just after an edge, with no relation to bus reads
    always_ff @(posedge i_clock) begin
        o_lines <= i_want;
        o_int_carrier <= i_want_int;
    end
endmodule
`default_nettype wire

// ---- msr_pkg.sv ----
// package for the modem line status readout block
package msr_pkg;
    // =====================================================================
    // register map
    localparam logic [3:0] MSR_ADDR_STATUS = 4'h0;
    localparam logic [3:0] MSR_ADDR_CTRL = 4'h4;
    localparam logic [3:0] MSR_ADDR_EVENT = 4'h8;

    // =====================================================================
    // status byte field positions
    localparam int MSR_BIT_CARRIER = 0;
    localparam int MSR_BIT_UNUSED = 1;
    localparam int MSR_BIT_CTS = 2;
    localparam int MSR_BIT_READY = 3;
    localparam int MSR_BIT_HALF = 4;

    // control register fields
    localparam int MSR_CTL_HALF = 0;
    localparam int MSR_CTL_INTMDM = 1;
    localparam int MSR_CTL_W = 2;
    localparam logic [MSR_CTL_W-1:0] MSR_CTL_RESET = 2'h0;

    // =====================================================================
    // raw modem lines carried together
    typedef struct packed {
        logic ready;
        logic cts;
        logic carrier;
    } msr_lines_s;

    // block state
    typedef struct packed {
        msr_lines_s sync1;
        msr_lines_s sync2;
        logic [MSR_CTL_W-1:0] ctrl;
        logic ready_drop;
        logic ready_prev;
        logic ack;
        logic [31:0] rdata;
    } msr_state_s;
endpackage

// ---- msr_readout.sv ----
// modem line status readout with classic wishbone slave
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - host reads modem lines over the bus; writable controls are software settable
// - bit 0 shows received line signal detect (carrier)
// - bit 1 is unused and always reads zero
// - bit 2 shows clear to send from the local modem
// - bit 3 shows modem ready, set when ready, clear otherwise
// - modem ready going inactive is caught as power loss or cable fault
// - bit 4 reads one in half-duplex mode
// - bit 4 reads zero in full-duplex mode
module msr_readout
    import msr_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_ext_carrier,
    input wire logic i_int_carrier,
    input wire logic i_clear_to_send,
    input wire logic i_modem_ready,
    output logic o_half_duplex,
    output logic o_modem_fault
);
    // =====================================================================
    // elaboration check
    if (ADDR_W < 4) begin : g_bad_addr
        $error("msr_readout: ADDR_W must be at least 4");
    end

    msr_state_s st_r;
    msr_state_s st_nxt;
    msr_lines_s raw;
    logic [7:0] status_byte;
    logic req;
    logic ready_fell;

    // =====================================================================
    // carrier source select, built-in modem or external line
    always_comb begin
        raw.carrier = st_r.ctrl[MSR_CTL_INTMDM] ? i_int_carrier : i_ext_carrier;
        raw.cts = i_clear_to_send;
        raw.ready = i_modem_ready;
    end

    // status byte from synchronised lines and the half-duplex control bit only, so a read is stable
    always_comb begin
        status_byte = 8'h00;
        status_byte[MSR_BIT_CARRIER] = st_r.sync2.carrier;
        status_byte[MSR_BIT_UNUSED] = 1'b0;
        status_byte[MSR_BIT_CTS] = st_r.sync2.cts;
        status_byte[MSR_BIT_READY] = st_r.sync2.ready;
        status_byte[MSR_BIT_HALF] = st_r.ctrl[MSR_CTL_HALF];
    end

    assign req = i_wb_cyc && i_wb_stb && !st_r.ack;

    // ready edge from the second stage and its delayed copy only; the first
    // stage may still be settling, so nothing but the second stage reads it
    assign ready_fell = st_r.ready_prev && !st_r.sync2.ready;

    // =====================================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = raw;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.ack = req;
        // delayed copy of the second stage for the edge detect
        st_nxt.ready_prev = st_r.sync2.ready;
        if (ready_fell) begin
            st_nxt.ready_drop = 1'b1;
        end
        if (req) begin
            st_nxt.rdata = 32'h0000_0000;
            if (i_wb_adr[3:0] == MSR_ADDR_STATUS) begin
                st_nxt.rdata = {24'h00_0000, status_byte};
            end else if (i_wb_adr[3:0] == MSR_ADDR_CTRL) begin
                st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
                if (i_wb_we && i_wb_sel[0]) begin
                    st_nxt.ctrl = i_wb_dat[MSR_CTL_W-1:0];
                end
            end else if (i_wb_adr[3:0] == MSR_ADDR_EVENT) begin
                st_nxt.rdata = {31'h0000_0000, st_r.ready_drop};
                // write one clears; a new drop in the same cycle wins
                if (i_wb_we && i_wb_sel[0] && i_wb_dat[0] && !ready_fell) begin
                    st_nxt.ready_drop = 1'b0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.ctrl <= MSR_CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_ack = st_r.ack;
    assign o_wb_dat = st_r.rdata;
    assign o_half_duplex = st_r.ctrl[MSR_CTL_HALF];
    assign o_modem_fault = st_r.ready_drop;

    // =====================================================================
    // assertions
    property p_unused_zero;
        @(posedge i_clock) disable iff (i_sys_rst)
            o_wb_ack && $past(i_wb_adr[3:0]) == MSR_ADDR_STATUS |->
            o_wb_dat[MSR_BIT_UNUSED] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("bit 1 not zero");

    property p_cts_sync;
        @(posedge i_clock) disable iff (i_sys_rst)
            i_clear_to_send [*3] |-> st_r.sync2.cts;
    endproperty
    a_cts_sync: assert property (p_cts_sync) else $error("cts not through sync");

    property p_ready_bit;
        @(posedge i_clock) disable iff (i_sys_rst)
            !$past(i_sys_rst, 2) |-> status_byte[MSR_BIT_READY] == $past(i_modem_ready, 2);
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("ready bit wrong");

    property p_drop_flag;
        @(posedge i_clock) disable iff (i_sys_rst)
            ready_fell |=> o_modem_fault;
    endproperty
    a_drop_flag: assert property (p_drop_flag) else $error("ready drop lost");

    property p_half;
        @(posedge i_clock) disable iff (i_sys_rst)
            i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0]
            && i_wb_adr[3:0] == MSR_ADDR_CTRL |=> status_byte[MSR_BIT_HALF] ==
            $past(i_wb_dat[MSR_CTL_HALF]) && o_half_duplex == status_byte[MSR_BIT_HALF];
    endproperty
    a_half: assert property (p_half) else $error("duplex bit mismatch");

    property p_carrier_int;
        @(posedge i_clock) disable iff (i_sys_rst)
            st_r.ctrl[MSR_CTL_INTMDM] && $stable(st_r.ctrl) && i_int_carrier
            ##1 $stable(st_r.ctrl) && i_int_carrier |=> status_byte[MSR_BIT_CARRIER];
    endproperty
    a_carrier_int: assert property (p_carrier_int) else $error("internal carrier lost");

    property p_carrier_ext;
        @(posedge i_clock) disable iff (i_sys_rst)
            !st_r.ctrl[MSR_CTL_INTMDM] && !i_ext_carrier ##1
            !st_r.ctrl[MSR_CTL_INTMDM] && !i_ext_carrier |=> !status_byte[MSR_BIT_CARRIER];
    endproperty
    a_carrier_ext: assert property (p_carrier_ext) else $error("external carrier wrong");

    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    property p_ack;
        @(posedge i_clock) disable iff (i_sys_rst)
            s_req |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    // a control write lands on the taking edge
    sequence s_ctrl_write;
        s_req ##0 (i_wb_we && i_wb_sel[0] && i_wb_adr[3:0] == MSR_ADDR_CTRL);
    endsequence
    property p_ctrl_write;
        @(posedge i_clock) disable iff (i_sys_rst)
            s_ctrl_write |=> st_r.ctrl == $past(i_wb_dat[MSR_CTL_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // status read returns the byte of the taking edge, upper bits zero
    property p_status_read;
        @(posedge i_clock) disable iff (i_sys_rst)
            o_wb_ack && $past(i_wb_adr[3:0]) == MSR_ADDR_STATUS |->
            o_wb_dat == {24'h00_0000, $past(status_byte)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // unmapped offsets read zero but are still acknowledged
    property p_refused;
        @(posedge i_clock) disable iff (i_sys_rst)
            o_wb_ack && $past(i_wb_adr[3:0]) != MSR_ADDR_STATUS
            && $past(i_wb_adr[3:0]) != MSR_ADDR_CTRL
            && $past(i_wb_adr[3:0]) != MSR_ADDR_EVENT |-> o_wb_dat == 32'h0000_0000;
    endproperty
    a_refused: assert property (p_refused) else $error("unmapped read not zero");

    // write one clears the fault unless a new drop comes with it
    sequence s_event_clear;
        s_req ##0 (i_wb_we && i_wb_sel[0] && i_wb_dat[0]
            && i_wb_adr[3:0] == MSR_ADDR_EVENT);
    endsequence
    property p_fault_clear;
        @(posedge i_clock) disable iff (i_sys_rst)
            s_event_clear ##0 !ready_fell |=> !o_modem_fault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault clear lost");

    // sticky, so a short cable fault is not missed by a slow poll
    property p_fault_sticky;
        @(posedge i_clock) disable iff (i_sys_rst)
            o_modem_fault && !(i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we
            && i_wb_adr[3:0] == MSR_ADDR_EVENT) |=> o_modem_fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault not sticky");

    // reset leaves full duplex, no fault and no acknowledge
    property p_reset_clear;
        @(posedge i_clock) i_sys_rst |=> !o_wb_ack && !o_modem_fault && !o_half_duplex;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
endmodule

`default_nettype wire

// ---- tb_msr_readout.sv ----
// self-checking testbench for the modem line status readout
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench
module tb_msr_readout import msr_pkg::*;;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] o_wb_dat;
    logic o_wb_ack, o_half_duplex, o_modem_fault, int_c;
    msr_lines_s want = '0;
    msr_lines_s lines;
    logic want_int = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    always #20 i_clock = ~i_clock;
    msr_modem_model i_msr_modem_model (.i_clock(i_clock), .i_want(want),
        .i_want_int(want_int), .o_lines(lines), .o_int_carrier(int_c));
    msr_readout #(.ADDR_W(4)) i_msr_readout (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_ext_carrier(lines.carrier), .i_int_carrier(int_c),
        .i_clear_to_send(lines.cts), .i_modem_ready(lines.ready),
        .o_half_duplex(o_half_duplex), .o_modem_fault(o_modem_fault));
    // verdict in one place, also used when a wait runs out
    task automatic tally_and_finish();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rdat = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge i_clock);
    endtask
    // every line pattern under every control setting
    initial begin
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        wb(1'b0, MSR_ADDR_STATUS, 32'h0, 4'h1);
        chk(rdat, 32'h0);
        for (int m = 0; m < 32; m++) begin
            want <= m[2:0];
            want_int <= ~m[0];
            wb(1'b1, MSR_ADDR_CTRL, {30'h0, m[4], m[3]}, 4'h1);
            repeat (2) @(posedge i_clock); // two sync stages settle first
            wb(1'b0, MSR_ADDR_STATUS, 32'h0, 4'h1);
            chk(rdat, {27'h0, m[3], m[2], m[1], 1'b0, m[4] ^ m[0]});
            chk({31'h0, o_half_duplex}, {31'h0, m[3]});
        end
        wb(1'b0, MSR_ADDR_EVENT, 32'h0, 4'h1);
        chk(rdat, 32'h1);
        wb(1'b1, MSR_ADDR_EVENT, 32'h1, 4'h1);
        wb(1'b0, MSR_ADDR_EVENT, 32'h0, 4'h1);
        chk({rdat[30:0], o_modem_fault}, 32'h0);
        // ready falls so that its edge meets a clear request; the drop wins
        want <= '0;
        repeat (3) @(posedge i_clock);
        wb(1'b1, MSR_ADDR_EVENT, 32'h1, 4'h1);
        chk({31'h0, o_modem_fault}, 32'h1);
        wb(1'b1, MSR_ADDR_EVENT, 32'h1, 4'h1);
        chk({31'h0, o_modem_fault}, 32'h0);
        // plain drop: ready up through the syncs, then down again
        want <= 3'h4;
        repeat (4) @(posedge i_clock);
        want <= '0;
        repeat (6) @(posedge i_clock);
        chk({31'h0, o_modem_fault}, 32'h1);
        wb(1'b1, 4'hc, 32'hff, 4'h1);
        wb(1'b0, 4'hc, 32'h0, 4'h1);
        chk(rdat, 32'h0);
        wb(1'b1, MSR_ADDR_STATUS, 32'h1f, 4'h1);
        wb(1'b0, MSR_ADDR_STATUS, 32'h0, 4'h1);
        chk(rdat, 32'h10);
        // byte lane 0 off: control must keep its value
        wb(1'b1, MSR_ADDR_CTRL, 32'h0, 4'he);
        wb(1'b0, MSR_ADDR_CTRL, 32'h0, 4'h1);
        chk(rdat, 32'h3);
        // mid-run reset clears control and the sticky fault
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        chk({30'h0, o_half_duplex, o_modem_fault}, 32'h0);
        wb(1'b0, MSR_ADDR_CTRL, 32'h0, 4'h1);
        chk(rdat, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
